/* File: include/oeg_pkg.sv */
// Package for the operand format and effective-address generator
package oeg_pkg;
    // ------------------------------------------------------------
    // Operand sizes and formats
    // ------------------------------------------------------------
    localparam int SIZE_W         = 3;
    localparam logic [2:0] SZ_BYTE = 3'h0;
    localparam logic [2:0] SZ_WORD = 3'h1;
    localparam logic [2:0] SZ_LONG = 3'h2;
    localparam logic [2:0] SZ_QUAD = 3'h3;
    localparam logic [2:0] SZ_BLK  = 3'h4;
    localparam logic [2:0] SZ_SGL  = 3'h5;
    localparam logic [2:0] SZ_DBL  = 3'h6;
    localparam logic [2:0] SZ_EXT  = 3'h7;
    localparam int SGL_EXP_W = 8;
    localparam int SGL_MAN_W = 23;
    localparam int DBL_EXP_W = 11;
    localparam int DBL_MAN_W = 52;
    localparam int EXT_EXP_W = 15;
    localparam int EXT_MAN_W = 64;
    localparam int SGL_BIAS  = 127;
    localparam int DBL_BIAS  = 1023;
    localparam int EXT_BIAS  = 16383;
    localparam int BLK_ALIGN_BITS = 4;
    localparam logic [31:0] EXT_MEM_BYTES = 32'h0000_000C;
    localparam int BF_MAX_W  = 32;
    localparam int BCD_PACKED_DIGITS   = 2;
    localparam int BCD_UNPACKED_DIGITS = 1;
    // ------------------------------------------------------------
    // Addressing modes
    // ------------------------------------------------------------
    localparam logic [3:0] AM_IND     = 4'h0;
    localparam logic [3:0] AM_POSTINC = 4'h1;
    localparam logic [3:0] AM_PREDEC  = 4'h2;
    localparam logic [3:0] AM_DISP16  = 4'h3;
    localparam logic [3:0] AM_IDX8    = 4'h4;
    localparam logic [3:0] AM_IDXBD   = 4'h5;
    localparam logic [3:0] AM_MPOST   = 4'h6;
    localparam logic [3:0] AM_MPRE    = 4'h7;
    localparam logic [3:0] AM_ABS_W   = 4'h8;
    localparam logic [3:0] AM_ABS_L   = 4'h9;
    localparam logic [3:0] AM_IMM     = 4'hA;
    localparam logic [3:0] AM_REG     = 4'hB;
    typedef enum logic [1:0] {
        OEG_IDLE  = 2'b00,
        OEG_FETCH = 2'b01,
        OEG_DONE  = 2'b11
    } oeg_state_t;
endpackage

/* File: rtl/oeg_top.sv */
// Effective-address generation and operand format conversion
`timescale 1ns/1ps
module oeg_top
    import oeg_pkg::*;
(
    input  wire logic        clk,            // Core clock
    input  wire logic        rst,            // Sync reset, high
    input  wire logic        req_valid,      // Address request
    output logic             req_ready,      // Ready for request
    input  wire logic [3:0]  mode,           // Addressing mode
    input  wire logic        use_pc,         // Base is PC not addr_reg_n
    input  wire logic [2:0]  op_size,        // Operand size code
    input  wire logic [31:0] addr_reg_n,     // Address register value
    input  wire logic [31:0] pc,             // Program counter
    input  wire logic [31:0] index_reg,      // Index register value
    input  wire logic        index_long,     // Index long, else word
    input  wire logic [1:0]  index_scale,    // Scale log2: 1,2,4,8
    input  wire logic        index_sup,      // Index suppressed
    input  wire logic [31:0] base_disp,      // Base/short displacement
    input  wire logic [1:0]  base_disp_sz,   // 0 none,1 byte,2 word,3 long
    input  wire logic [31:0] outer_disp,     // Outer displacement
    input  wire logic [1:0]  outer_disp_sz,  // 0 none,2 word,3 long
    input  wire logic [31:0] ext_word,       // Abs address or immediate
    output logic             fetch_req,      // Pointer fetch request
    output logic [31:0]      fetch_addr,     // Pointer fetch address
    input  wire logic        fetch_ack,      // Pointer fetch returned
    input  wire logic [31:0] fetch_data,     // Fetched pointer
    output logic             ea_valid,       // Result pulse
    output logic [31:0]      ea,             // Effective address
    output logic             ea_is_imm,      // ea holds immediate data
    output logic [31:0]      areg_wb,        // Updated address register
    output logic             areg_wb_en,     // Write back address register
    output logic             align_err,      // Block not 16-byte aligned
    input  wire logic [31:0] int_in,         // Integer to convert
    output logic [79:0]      ext_out         // Extended real from integer
);
    import oeg_pkg::*;

    function automatic logic [31:0] sx(input logic [31:0] v, input logic [1:0] sz);
        case (sz)
            2'd0:    sx = 32'h0000_0000;
            2'd1:    sx = {{24{v[7]}}, v[7:0]};
            2'd2:    sx = {{16{v[15]}}, v[15:0]};
            default: sx = v;
        endcase
    endfunction

    function automatic logic [31:0] bytes_of(input logic [2:0] sz);
        case (sz)
            SZ_BYTE: bytes_of = 32'h0000_0001;
            SZ_WORD: bytes_of = 32'h0000_0002;
            SZ_LONG: bytes_of = 32'h0000_0004;
            SZ_SGL:  bytes_of = 32'h0000_0004;
            SZ_QUAD: bytes_of = 32'h0000_0008;
            SZ_DBL:  bytes_of = 32'h0000_0008;
            SZ_EXT:  bytes_of = EXT_MEM_BYTES;
            default: bytes_of = 32'h0000_0010;
        endcase
    endfunction

    typedef struct packed {
        oeg_state_t  st;
        logic        fetch_req;
        logic [31:0] fetch_addr;
        logic [31:0] post_add;
        logic        is_blk;
        logic        ea_valid;
        logic [31:0] ea;
        logic        ea_is_imm;
        logic [31:0] areg_wb;
        logic        areg_wb_en;
        logic        align_err;
        logic [79:0] ext_out;
    } oeg_s_t;

    oeg_s_t st_ff;
    oeg_s_t nxt_st;

    logic [31:0] base;
    logic [31:0] idx;
    logic [31:0] bd;
    logic [31:0] od;
    logic [31:0] sum_ea;
    logic        is_mem;
    logic [31:0] mag;
    logic [5:0]  lz;
    logic [63:0] norm;

    assign base = use_pc ? pc : addr_reg_n;
    // Index sized first, then scaled
    assign idx = index_sup ? 32'h0000_0000 :
                 ((index_long ? index_reg : sx(index_reg, 2'd2)) << index_scale);
    assign bd  = sx(base_disp, base_disp_sz);
    assign od  = sx(outer_disp, outer_disp_sz);
    assign req_ready = (st_ff.st == OEG_IDLE);

    // Integer to extended real: two's complement in, normalised out
    always_comb begin
        mag  = int_in[31] ? (~int_in + 32'h0000_0001) : int_in;
        lz   = 6'd32;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                lz = 6'(31 - i);
            end
        end
        norm = {mag, 32'h0000_0000} << lz;
    end

    always_comb begin
        nxt_st            = st_ff;
        nxt_st.ea_valid   = 1'b0;
        nxt_st.areg_wb_en = 1'b0;
        sum_ea            = 32'h0000_0000;
        is_mem            = 1'b0;
        if (mag == 32'h0000_0000) begin
            nxt_st.ext_out = 80'h0;
        end else begin
            nxt_st.ext_out = {int_in[31], 15'(16383 + 31 - int'(lz)), norm};
        end
        case (st_ff.st)
            OEG_IDLE: begin
                if (req_valid) begin
                    case (mode)
                        AM_IND:     sum_ea = base;
                        AM_POSTINC: sum_ea = base;
                        AM_PREDEC:  sum_ea = base - bytes_of(op_size);
                        AM_DISP16:  sum_ea = base + sx(base_disp, 2'd2);
                        AM_IDX8:    sum_ea = base + sx(base_disp, 2'd1) + idx;
                        AM_IDXBD:   sum_ea = base + bd + idx;
                        AM_ABS_W:   sum_ea = sx(ext_word, 2'd2);
                        AM_ABS_L:   sum_ea = ext_word;
                        AM_IMM:     sum_ea = ext_word;
                        default:    sum_ea = base;
                    endcase
                    is_mem = (mode == AM_MPOST) || (mode == AM_MPRE);
                    if (is_mem) begin
                        nxt_st.st         = OEG_FETCH;
                        nxt_st.fetch_req  = 1'b1;
                        nxt_st.fetch_addr = base + bd + ((mode == AM_MPRE) ? idx : 32'h0000_0000);
                        nxt_st.post_add   = od + ((mode == AM_MPOST) ? idx : 32'h0000_0000);
                        // Size kept from the request; op_size may move on during the fetch
                        nxt_st.is_blk     = (op_size == SZ_BLK);
                    end else begin
                        nxt_st.st         = OEG_DONE;
                        nxt_st.ea         = sum_ea;
                        nxt_st.ea_is_imm  = (mode == AM_IMM);
                        nxt_st.areg_wb_en = (mode == AM_POSTINC) || (mode == AM_PREDEC);
                        nxt_st.areg_wb    = (mode == AM_POSTINC) ?
                                            base + bytes_of(op_size) : sum_ea;
                        nxt_st.align_err  = (op_size == SZ_BLK) && (mode != AM_IMM)
                                            && (sum_ea[3:0] != 4'h0);
                        nxt_st.ea_valid   = 1'b1;
                    end
                end
            end
            OEG_FETCH: begin
                if (fetch_ack) begin
                    nxt_st.fetch_req = 1'b0;
                    nxt_st.ea        = fetch_data + st_ff.post_add;
                    nxt_st.ea_is_imm = 1'b0;
                    nxt_st.align_err = st_ff.is_blk &&
                                       ((fetch_data[3:0] + st_ff.post_add[3:0]) != 4'h0);
                    nxt_st.ea_valid  = 1'b1;
                    nxt_st.st        = OEG_DONE;
                end
            end
            OEG_DONE: nxt_st.st = OEG_IDLE;
            default:  nxt_st.st = OEG_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fetch_req  = st_ff.fetch_req;
    assign fetch_addr = st_ff.fetch_addr;
    assign ea_valid   = st_ff.ea_valid;
    assign ea         = st_ff.ea;
    assign ea_is_imm  = st_ff.ea_is_imm;
    assign areg_wb    = st_ff.areg_wb;
    assign areg_wb_en = st_ff.areg_wb_en;
    assign align_err  = st_ff.align_err;
    assign ext_out    = st_ff.ext_out;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    disp_mode_a: assert property (@(posedge clk) disable iff (rst)
        (req_ready && req_valid && mode == AM_DISP16) |=>
        ea == $past(base) + {{16{$past(base_disp[15])}}, $past(base_disp[15:0])})
        else $error("disp16 address wrong");
    predec_mode_a: assert property (@(posedge clk) disable iff (rst)
        (req_ready && req_valid && mode == AM_PREDEC && op_size == SZ_LONG && !use_pc) |=>
        ea == $past(addr_reg_n) - 32'h0000_0004 && areg_wb == ea && areg_wb_en)
        else $error("predecrement wrong");
    postinc_mode_a: assert property (@(posedge clk) disable iff (rst)
        (req_ready && req_valid && mode == AM_POSTINC && op_size == SZ_WORD && !use_pc) |=>
        ea == $past(addr_reg_n) && areg_wb == ea + 32'h0000_0002)
        else $error("postincrement wrong");
    abs_short_a: assert property (@(posedge clk) disable iff (rst)
        (req_ready && req_valid && mode == AM_ABS_W) |=>
        ea == {{16{$past(ext_word[15])}}, $past(ext_word[15:0])})
        else $error("absolute short not sign-extended");
    idx8_mode_a: assert property (@(posedge clk) disable iff (rst)
        (req_ready && req_valid && mode == AM_IDX8 && index_sup) |=>
        ea == $past(base) + {{24{$past(base_disp[7])}}, $past(base_disp[7:0])})
        else $error("8-bit index displacement wrong");
    mem_fetch_a: assert property (@(posedge clk) disable iff (rst)
        (req_ready && req_valid && mode == AM_MPOST) |=>
        fetch_req && fetch_addr == $past(base) + $past(bd))
        else $error("postindexed fetch address wrong");
    mem_result_a: assert property (@(posedge clk) disable iff (rst)
        (st_ff.st == OEG_FETCH && fetch_ack) |=>
        ea_valid && ea == $past(fetch_data) + $past(st_ff.post_add))
        else $error("memory indirect result wrong");
    blk_align_a: assert property (@(posedge clk) disable iff (rst)
        (req_ready && req_valid && mode == AM_ABS_L && op_size == SZ_BLK) |=>
        align_err == ($past(ext_word[3:0]) != 4'h0))
        else $error("block alignment check wrong");
    ext_conv_a: assert property (@(posedge clk) disable iff (rst)
        (int_in == 32'h0000_0001) |=> ext_out == {1'b0, 15'h3FFF, 64'h8000_0000_0000_0000})
        else $error("integer one not converted");
    scale_idx_a: assert property (@(posedge clk) disable iff (rst)
        (req_ready && req_valid && mode == AM_IDXBD && !index_sup && !index_long
         && index_scale == 2'd3 && base_disp_sz == 2'd0) |=>
        ea == $past(base) + ({{16{$past(index_reg[15])}}, $past(index_reg[15:0])} << 3))
        else $error("scaled index wrong");
endmodule // oeg_top

/* File: sim/oeg_fetch_model.sv */
// Pointer-fetch responder standing in for the operand fetch path
`timescale 1ns/1ps
module oeg_fetch_model #(
    parameter logic [31:0] KEY = 32'h0000_0000
) (
    input  wire logic        clk,        // Core clock
    input  wire logic        rst,        // Sync reset, high
    input  wire logic        fetch_req,  // Pointer fetch request
    input  wire logic [31:0] fetch_addr, // Pointer fetch address
    input  wire logic [3:0]  delay,      // Wait cycles before answer
    output logic             fetch_ack,  // Answer pulse
    output logic [31:0]      fetch_data  // Pointer, churns when idle
);
    logic [3:0] wait_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            fetch_ack  <= 1'b0;
            fetch_data <= 32'h0000_0000;
            wait_ff    <= 4'h0;
        end else if (fetch_req && !fetch_ack && wait_ff == delay) begin
            fetch_ack  <= 1'b1;
            fetch_data <= fetch_addr ^ KEY;
            wait_ff    <= 4'h0;
        end else begin
            // Idle data churns so a stale pointer never looks valid
            fetch_ack  <= 1'b0;
            fetch_data <= ~fetch_data;
            wait_ff    <= (fetch_req && !fetch_ack) ? wait_ff + 4'h1 : 4'h0;
        end
    end
endmodule // oeg_fetch_model

/* File: sim/tb.sv */
// Self-checking bench for the effective-address generator
`timescale 1ns/1ps
module tb;
    import oeg_pkg::*;
    localparam logic [31:0] KEY = 32'h5A5A_A5A5;
    logic        clk, rst, req_valid, use_pc, index_long, index_sup, fetch_ack, req_ready;
    logic        fetch_req, ea_valid, ea_is_imm, areg_wb_en, align_err, got_wb, got_err, got_imm;
    logic [3:0]  mode, delay;
    logic [2:0]  op_size;
    logic [1:0]  index_scale, base_disp_sz, outer_disp_sz;
    logic [31:0] addr_reg_n, pc, index_reg, base_disp, outer_disp, ext_word, int_in;
    logic [31:0] fetch_addr, fetch_data, ea, areg_wb, got_fa, got_ea, got_wv;
    logic [79:0] ext_out;
    int          n_errors = 0, samples_checked = 0, cycles = 0;

    oeg_top DUT (.clk, .rst, .req_valid, .req_ready, .mode, .use_pc, .op_size, .addr_reg_n,
        .pc, .index_reg, .index_long, .index_scale, .index_sup, .base_disp, .base_disp_sz,
        .outer_disp, .outer_disp_sz, .ext_word, .fetch_req, .fetch_addr, .fetch_ack,
        .fetch_data, .ea_valid, .ea, .ea_is_imm, .areg_wb, .areg_wb_en, .align_err,
        .int_in, .ext_out);
    oeg_fetch_model #(.KEY(KEY)) fm (.clk, .rst, .fetch_req, .fetch_addr, .delay, .fetch_ack,
        .fetch_data);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Run is about a hundred cycles; ceiling leaves wide margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic se(input logic [3:0] m, input logic [31:0] a, input logic [31:0] b,
                      input logic [1:0] bs, input logic [31:0] o, input logic [1:0] os);
        mode = m;
        addr_reg_n = a;
        base_disp = b;
        base_disp_sz = bs;
        outer_disp = o;
        outer_disp_sz = os;
    endtask
    task automatic sx(input logic [31:0] x, input logic l, input logic [1:0] s, input logic u);
        index_reg = x;
        index_long = l;
        index_scale = s;
        index_sup = u;
    endtask
    // Waits for ready, issues one request, captures the result pulse
    task automatic go();
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        got_fa = 32'h0000_0000;
        k = 0;
        while (ea_valid !== 1'b1 && k < 40) begin
            if (fetch_req === 1'b1) got_fa = fetch_addr;
            @(posedge clk);
            #1;
            k++;
        end
        check(ea_valid, 1'b1);
        got_ea = ea;
        got_wb = areg_wb_en;
        got_wv = areg_wb;
        got_err = align_err;
        got_imm = ea_is_imm;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_indirect();
        logic [2:0]  sz [8] = '{SZ_BYTE, SZ_WORD, SZ_LONG, SZ_QUAD, SZ_BLK, SZ_SGL, SZ_DBL, SZ_EXT};
        logic [31:0] st [8] = '{1, 2, 4, 8, 16, 4, 8, 12};
        se(AM_IND, 32'h0000_1000, 32'h0000_0000, 2'd0, 32'h0000_0000, 2'd0);
        go();
        check(got_ea, 32'h0000_1000);
        check(got_wb, 1'b0);
        for (int i = 0; i < 8; i++) begin
            op_size = sz[i];
            mode = AM_POSTINC;
            go();
            check(got_ea, 32'h0000_1000);
            check(got_wb, 1'b1);
            check(got_wv, 32'h0000_1000 + st[i]);
            mode = AM_PREDEC;
            go();
            check(got_ea, 32'h0000_1000 - st[i]);
            check(got_wv, 32'h0000_1000 - st[i]);
        end
    endtask
    task automatic t_disp();
        se(AM_DISP16, 32'h0001_0000, 32'hFFFF_8000, 2'd2, 32'h0000_0000, 2'd0);
        op_size = SZ_LONG;
        go();
        check(got_ea, 32'h0000_8000);
        base_disp = 32'h0000_7FFE;
        use_pc = 1'b1;
        pc = 32'h0002_0000;
        go();
        check(got_ea, 32'h0002_7FFE);
        use_pc = 1'b0;
    endtask
    task automatic t_index();
        se(AM_IDX8, 32'h0000_2000, 32'h0000_00F0, 2'd1, 32'h0000_0000, 2'd0);
        sx(32'h0001_FFFE, 1'b0, 2'd0, 1'b0);
        for (int s = 0; s < 4; s++) begin
            index_scale = s[1:0];
            go();
            check(got_ea, 32'h0000_1FF0 - (32'h0000_0002 << s));
        end
        index_long = 1'b1;
        go();
        check(got_ea, 32'h0000_1FF0 + (32'h0001_FFFE << 3));
        index_sup = 1'b1;
        go();
        check(got_ea, 32'h0000_1FF0);
        se(AM_IDXBD, 32'h0000_2000, 32'h0000_1234, 2'd0, 32'h0000_0000, 2'd0);
        index_sup = 1'b0;
        go();
        check(got_ea, 32'h0000_2000 + (32'h0001_FFFE << 3));
        index_long = 1'b0;
        go();
        check(got_ea, 32'h0000_1FF0);
        index_long = 1'b1;
        base_disp_sz = 2'd3;
        use_pc = 1'b1;
        go();
        check(got_ea, 32'h0002_1234 + (32'h0001_FFFE << 3));
        use_pc = 1'b0;
    endtask
    task automatic t_memind();
        se(AM_MPOST, 32'h0000_0000, 32'h0000_0100, 2'd2, 32'h1234_FFFC, 2'd2);
        sx(32'h0000_0003, 1'b1, 2'd2, 1'b0);
        use_pc = 1'b1;
        pc = 32'h0004_0000;
        for (int d = 0; d < 2; d++) begin
            delay = (d == 0) ? 4'd0 : 4'd5;
            mode = AM_MPOST;
            go();
            check(got_fa, 32'h0004_0100);
            check(got_ea, (32'h0004_0100 ^ KEY) + 32'h0000_0008);
            mode = AM_MPRE;
            go();
            check(got_fa, 32'h0004_010C);
            check(got_ea, (32'h0004_010C ^ KEY) - 32'h0000_0004);
        end
        use_pc = 1'b0;
    endtask
    task automatic t_abs_blk();
        se(AM_ABS_W, 32'h0000_1008, 32'h0000_0000, 2'd0, 32'h0000_0000, 2'd0);
        ext_word = 32'h0000_8000;
        go();
        check(got_ea, 32'hFFFF_8000);
        mode = AM_ABS_L;
        ext_word = 32'h8765_4321;
        go();
        check(got_ea, 32'h8765_4321);
        mode = AM_IMM;
        go();
        check(got_imm, 1'b1);
        mode = AM_IND;
        op_size = SZ_BLK;
        go();
        check(got_err, 1'b1);
        addr_reg_n = 32'h0000_1010;
        go();
        check(got_err, 1'b0);
        mode = AM_ABS_L;
        go();
        check(got_err, 1'b1);
        ext_word = 32'h8765_4320;
        go();
        check(got_err, 1'b0);
    endtask
    task automatic t_conv();
        logic [31:0] vi [4] = '{32'h0000_0001, 32'hFFFF_FFFF, 32'h8000_0000, 32'h0000_0006};
        logic [79:0] vo [4] = '{{16'h3FFF, 64'h8000_0000_0000_0000},
            {16'hBFFF, 64'h8000_0000_0000_0000}, {16'hC01E, 64'h8000_0000_0000_0000},
            {16'h4001, 64'hC000_0000_0000_0000}};
        for (int i = 0; i < 4; i++) begin
            int_in = vi[i];
            @(posedge clk);
            #1;
            check(ext_out, vo[i]);
        end
    endtask

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        use_pc = 1'b0;
        op_size = SZ_LONG;
        pc = 32'h0000_0000;
        ext_word = 32'h0000_0000;
        int_in = 32'h0000_0000;
        delay = 4'd0;
        se(AM_IND, 32'h0000_0000, 32'h0000_0000, 2'd0, 32'h0000_0000, 2'd0);
        sx(32'h0000_0000, 1'b0, 2'd0, 1'b0);
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_indirect();
        t_disp();
        t_index();
        t_memind();
        t_abs_blk();
        t_conv();
        report_and_stop();
    end
endmodule // tb
